//--- dit_params.svh
// Register map, field positions, reset values and prescale constants of the dual timer
`ifndef DIT_PARAMS_SVH
`define DIT_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DIT_ADDR_W 18
`define DIT_IDX_PORT0_FUNC 16'hfe42
`define DIT_IDX_CTRL 16'hfe78
`define DIT_IDX_A_PERIOD 16'hfe7a
`define DIT_IDX_B_PERIOD 16'hfe7b
`define DIT_IDX_PIN_CTRL 16'hfe80
`define DIT_IDX_A_COUNT 16'hfe81
`define DIT_IDX_B_COUNT 16'hfe82

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DIT_CTRL_B_SEL_HI 7
`define DIT_CTRL_B_SEL_LO 6
`define DIT_CTRL_A_SEL_HI 5
`define DIT_CTRL_A_SEL_LO 4
`define DIT_CTRL_B_OVF 3
`define DIT_CTRL_B_IE 2
`define DIT_CTRL_A_OVF 1
`define DIT_CTRL_A_IE 0
`define DIT_FUNC_B_OE 7
`define DIT_FUNC_A_OE 6
`define DIT_PIN_A_LATCH 0
`define DIT_PIN_B_LATCH 1
`define DIT_PIN_A_DIR 2
`define DIT_PIN_B_DIR 3

// ----------------------------------------------------------------
// Reset values and prescale
// ----------------------------------------------------------------
`define DIT_RST_BYTE 8'h00
`define DIT_RST_PIN 4'h0
`define DIT_SEL_STOP 2'h0
`define DIT_SEL_DIV4 2'h1
`define DIT_SEL_DIV16 2'h2
`define DIT_SEL_DIV64 2'h3
`define DIT_LAST_DIV4 6'h03
`define DIT_LAST_DIV16 6'h0f
`define DIT_LAST_DIV64 6'h3f

`endif

//--- dit_pkg.sv
// Types shared by the dual timer modules
package dit_pkg;
	typedef logic [31:0] dit_word_t;
	typedef logic [7:0] dit_byte_t;
	typedef logic [1:0] dit_sel_t;
	typedef enum logic [1:0] {
		DIT_ST_STOP = 2'b01,
		DIT_ST_RUN = 2'b10
	} dit_state_t;
endpackage

//--- dit_chan_if.sv
// Link between the register block and one timer channel
`timescale 1ns/1ps
interface dit_chan_if;
	logic [1:0] clksel;
	logic [7:0] period;
	logic period_wr;
	logic ce;
	logic ovf;
	logic [7:0] count;
	logic toggle;
	modport ctrl(output clksel, output period, output period_wr, output ce,
		input ovf, input count, input toggle);
	modport chan(input clksel, input period, input period_wr, input ce,
		output ovf, output count, output toggle);
endinterface

//--- dit_chan.sv
// One interval timer channel: prescaler, period counter, toggle waveform
`timescale 1ns/1ps
`include "dit_params.svh"
module dit_chan #(
	parameter int PRE_W = 6,
	parameter int CNT_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	dit_chan_if.chan bus
);
	import dit_pkg::*;

	// ----------------------------------------------------------------
	// Prescale decode
	// ----------------------------------------------------------------
	function automatic logic [PRE_W-1:0] last_tick(input logic [1:0] sel);
		logic [PRE_W-1:0] r;
		r = `DIT_LAST_DIV64;
		unique case (sel)
			`DIT_SEL_DIV4: r = `DIT_LAST_DIV4;
			`DIT_SEL_DIV16: r = `DIT_LAST_DIV16;
			`DIT_SEL_DIV64: r = `DIT_LAST_DIV64;
			`DIT_SEL_STOP: r = `DIT_LAST_DIV64;
		endcase
		return r;
	endfunction

	dit_state_t state, next_state;
	logic [PRE_W-1:0] prescaler, next_prescaler;
	logic [CNT_W-1:0] counter, next_counter;
	logic toggle, next_toggle;
	logic ovf, next_ovf;
	logic tick;
	logic running;

	assign running = (bus.clksel != `DIT_SEL_STOP);
	assign tick = (prescaler >= last_tick(bus.clksel));

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_prescaler = prescaler;
		next_counter = counter;
		next_toggle = toggle;
		// Pulse held while frozen so the flag logic sees it exactly once
		next_ovf = bus.ce ? 1'b0 : ovf;
		if (bus.ce) begin
			unique case (state)
				DIT_ST_STOP: begin
					next_prescaler = '0;
					next_counter = '0;
					next_toggle = 1'b0;
					if (running) begin
						next_state = DIT_ST_RUN;
						// Start cycle already counts as first prescale cycle
						next_prescaler = {{(PRE_W-1){1'b0}}, 1'b1};
					end
				end
				DIT_ST_RUN: begin
					if (!running) begin
						next_state = DIT_ST_STOP;
						next_prescaler = '0;
						next_counter = '0;
						next_toggle = 1'b0;
					end else if (bus.period_wr) begin
						next_prescaler = '0;
						next_counter = '0;
					end else if (tick) begin
						next_prescaler = '0;
						if (counter == bus.period) begin
							next_counter = '0;
							next_ovf = 1'b1;
							next_toggle = ~toggle;
						end else begin
							next_counter = counter + 1'b1;
						end
					end else begin
						next_prescaler = prescaler + 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= DIT_ST_STOP;
			prescaler <= '0;
			counter <= '0;
			toggle <= 1'b0;
			ovf <= 1'b0;
		end else begin
			state <= next_state;
			prescaler <= next_prescaler;
			counter <= next_counter;
			toggle <= next_toggle;
			ovf <= next_ovf;
		end
	end

	assign bus.ovf = ovf;
	assign bus.count = counter;
	assign bus.toggle = toggle;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic [14:0] gap;
	logic clean;
	logic [1:0] sel_seen;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gap <= 15'h0000;
			clean <= 1'b0;
			sel_seen <= 2'h0;
		end else if (bus.ce) begin
			sel_seen <= bus.clksel;
			gap <= ovf ? 15'h0001 : gap + 15'h0001;
			if (bus.period_wr || bus.clksel != sel_seen)
				clean <= 1'b0;
			else if (ovf)
				clean <= 1'b1;
		end
	end

	period_len_a: assert property ((bus.ce && ovf && clean) |->
		gap == (({7'h00, bus.period} + 15'h0001) << {bus.clksel, 1'b0}))
		else $error("timer period length wrong");
	stop_zero_a: assert property ((bus.ce && !running) |=>
		(counter == 8'h00 && prescaler == 6'h00 && !toggle))
		else $error("stopped timer not cleared");
	wrap_flag_a: assert property ((bus.ce && state == DIT_ST_RUN && running
		&& !bus.period_wr && tick && counter == bus.period) |=> (ovf && counter == 8'h00))
		else $error("counter did not wrap with overflow");
	toggle_flip_a: assert property ((bus.ce && state == DIT_ST_RUN && running
		&& !bus.period_wr && tick && counter == bus.period) |=> (toggle != $past(toggle)))
		else $error("toggle did not invert at period end");
	restart_clear_a: assert property ((bus.ce && state == DIT_ST_RUN && running
		&& bus.period_wr) |=> (prescaler == 6'h00 && counter == 8'h00))
		else $error("period write did not restart timer");
endmodule

//--- dit_top.sv
// Dual interval timer with toggle pins and APB register access
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "dit_params.svh"
module dit_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`DIT_ADDR_W-1:0] paddr,
	input wire dit_pkg::dit_word_t pwdata,
	input wire logic [3:0] pstrb,
	output dit_pkg::dit_word_t prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic timer_a_toggle_pin_in,
	output logic timer_a_toggle_pin_out,
	output logic timer_a_toggle_pin_oe_n,
	input wire logic timer_b_toggle_pin_in,
	output logic timer_b_toggle_pin_out,
	output logic timer_b_toggle_pin_oe_n
);
	import dit_pkg::*;

	localparam int NCH = 2;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [`DIT_ADDR_W-1:0] addr,
		input logic [15:0] idx);
		return addr == {idx, 2'b00};
	endfunction

	dit_byte_t port0_function_control, next_port0_function_control;
	dit_byte_t dual_timer_control, next_dual_timer_control;
	dit_byte_t timer_a_period, next_timer_a_period;
	dit_byte_t timer_b_period, next_timer_b_period;
	logic [3:0] port0_pin_control, next_port0_pin_control;
	logic [NCH-1:0] pin_meta, pin_sync;
	logic [NCH-1:0] pin_out, next_pin_out;
	logic [NCH-1:0] pin_oe_n, next_pin_oe_n;
	logic irq_q, next_irq;
	dit_word_t rdata, next_rdata;
	logic err, next_err;

	logic wr_en, setup;
	logic hit_func, hit_ctrl, hit_a_per, hit_b_per, hit_pin, hit_a_cnt, hit_b_cnt;
	logic wr_ctrl, wr_a_per, wr_b_per;
	logic irq_cond;
	logic [NCH-1:0] pin_val;

	dit_sel_t sel_arr [NCH];
	dit_byte_t per_arr [NCH];
	logic [NCH-1:0] wr_arr, ovf_arr, tog_arr, dir_arr, latch_arr, oe_arr;
	dit_byte_t cnt_arr [NCH];

	assign wr_en = psel & penable & pwrite & ce & pstrb[0];
	assign setup = psel & ~penable & ce;
	assign hit_func = reg_hit(paddr, `DIT_IDX_PORT0_FUNC);
	assign hit_ctrl = reg_hit(paddr, `DIT_IDX_CTRL);
	assign hit_a_per = reg_hit(paddr, `DIT_IDX_A_PERIOD);
	assign hit_b_per = reg_hit(paddr, `DIT_IDX_B_PERIOD);
	assign hit_pin = reg_hit(paddr, `DIT_IDX_PIN_CTRL);
	assign hit_a_cnt = reg_hit(paddr, `DIT_IDX_A_COUNT);
	assign hit_b_cnt = reg_hit(paddr, `DIT_IDX_B_COUNT);
	assign wr_ctrl = wr_en & hit_ctrl;
	assign wr_a_per = wr_en & hit_a_per;
	assign wr_b_per = wr_en & hit_b_per;

	// Zero wait states; a frozen block stalls the bus instead of losing a write
	assign pready = ce;
	assign prdata = rdata;
	assign pslverr = err;
	assign irq = irq_q;

	// ----------------------------------------------------------------
	// Timer channels
	// ----------------------------------------------------------------
	assign sel_arr[0] = dual_timer_control[`DIT_CTRL_A_SEL_HI:`DIT_CTRL_A_SEL_LO];
	assign sel_arr[1] = dual_timer_control[`DIT_CTRL_B_SEL_HI:`DIT_CTRL_B_SEL_LO];
	assign per_arr[0] = timer_a_period;
	assign per_arr[1] = timer_b_period;
	assign wr_arr = {wr_b_per, wr_a_per};
	assign dir_arr = {port0_pin_control[`DIT_PIN_B_DIR], port0_pin_control[`DIT_PIN_A_DIR]};
	assign latch_arr = {port0_pin_control[`DIT_PIN_B_LATCH],
		port0_pin_control[`DIT_PIN_A_LATCH]};
	assign oe_arr = {port0_function_control[`DIT_FUNC_B_OE],
		port0_function_control[`DIT_FUNC_A_OE]};

	dit_chan_if chif [NCH] ();

	generate
		for (genvar i = 0; i < NCH; i++) begin : g_chan
			assign chif[i].clksel = sel_arr[i];
			assign chif[i].period = per_arr[i];
			assign chif[i].period_wr = wr_arr[i];
			assign chif[i].ce = ce;
			assign ovf_arr[i] = chif[i].ovf;
			assign cnt_arr[i] = chif[i].count;
			assign tog_arr[i] = chif[i].toggle;
			// pin value from latch, toggle and direction
			assign pin_val[i] = dir_arr[i] & (latch_arr[i] | (oe_arr[i] & tog_arr[i]));
			dit_chan #(
				.PRE_W(6),
				.CNT_W(8)
			) dit_chan_i (
				.sys_clk(sys_clk),
				.rst(rst),
				.bus(chif[i])
			);
		end
	endgenerate

	// one request line for both timers
	assign irq_cond = (dual_timer_control[`DIT_CTRL_A_IE] & dual_timer_control[`DIT_CTRL_A_OVF])
		| (dual_timer_control[`DIT_CTRL_B_IE] & dual_timer_control[`DIT_CTRL_B_OVF]);

	// ----------------------------------------------------------------
	// Register next values
	// ----------------------------------------------------------------
	always_comb begin
		next_port0_function_control = port0_function_control;
		next_dual_timer_control = dual_timer_control;
		next_timer_a_period = timer_a_period;
		next_timer_b_period = timer_b_period;
		next_port0_pin_control = port0_pin_control;
		next_rdata = rdata;
		next_err = err;
		if (wr_en && hit_func)
			next_port0_function_control = pwdata[7:0];
		if (wr_ctrl)
			next_dual_timer_control = pwdata[7:0];
		if (wr_a_per)
			next_timer_a_period = pwdata[7:0];
		if (wr_b_per)
			next_timer_b_period = pwdata[7:0];
		if (wr_en && hit_pin)
			next_port0_pin_control = pwdata[3:0];
		// set wins over a same-cycle software clear
		if (ce && ovf_arr[0])
			next_dual_timer_control[`DIT_CTRL_A_OVF] = 1'b1;
		// set wins over a same-cycle software clear
		if (ce && ovf_arr[1])
			next_dual_timer_control[`DIT_CTRL_B_OVF] = 1'b1;
		next_irq = irq_cond;
		next_pin_out = pin_val;
		next_pin_oe_n = ~dir_arr;
		if (setup) begin
			next_err = 1'b0;
			next_rdata = 32'h0000_0000;
			if (hit_func)
				next_rdata[7:0] = port0_function_control;
			else if (hit_ctrl)
				next_rdata[7:0] = dual_timer_control;
			else if (hit_a_per)
				next_rdata[7:0] = timer_a_period;
			else if (hit_b_per)
				next_rdata[7:0] = timer_b_period;
			else if (hit_pin)
				next_rdata[7:0] = {2'b00, pin_sync, port0_pin_control};
			else if (hit_a_cnt)
				next_rdata[7:0] = cnt_arr[0];
			else if (hit_b_cnt)
				next_rdata[7:0] = cnt_arr[1];
			else
				next_err = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			port0_function_control <= `DIT_RST_BYTE;
			dual_timer_control <= `DIT_RST_BYTE;
			timer_a_period <= `DIT_RST_BYTE;
			timer_b_period <= `DIT_RST_BYTE;
			port0_pin_control <= `DIT_RST_PIN;
			pin_meta <= '0;
			pin_sync <= '0;
			pin_out <= '0;
			pin_oe_n <= '1;
			irq_q <= 1'b0;
			rdata <= 32'h0000_0000;
			err <= 1'b0;
		end else if (ce) begin
			port0_function_control <= next_port0_function_control;
			dual_timer_control <= next_dual_timer_control;
			timer_a_period <= next_timer_a_period;
			timer_b_period <= next_timer_b_period;
			port0_pin_control <= next_port0_pin_control;
			pin_meta <= {timer_b_toggle_pin_in, timer_a_toggle_pin_in};
			pin_sync <= pin_meta;
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
			irq_q <= next_irq;
			rdata <= next_rdata;
			err <= next_err;
		end
	end

	assign timer_a_toggle_pin_out = pin_out[0];
	assign timer_a_toggle_pin_oe_n = pin_oe_n[0];
	assign timer_b_toggle_pin_out = pin_out[1];
	assign timer_b_toggle_pin_oe_n = pin_oe_n[1];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	irq_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce |=> (irq == $past(irq_cond)))
		else $error("interrupt line does not follow enabled flags");
	flag_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
		(dual_timer_control[`DIT_CTRL_A_OVF] && !wr_ctrl)
		|=> dual_timer_control[`DIT_CTRL_A_OVF])
		else $error("timer A flag cleared without write");
	flag_a_set_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && ovf_arr[0]) |=> dual_timer_control[`DIT_CTRL_A_OVF])
		else $error("timer A overflow lost");
	flag_b_set_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && ovf_arr[1]) |=> dual_timer_control[`DIT_CTRL_B_OVF])
		else $error("timer B overflow lost");
	pin_a_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
		ce |=> (timer_a_toggle_pin_out == $past(pin_val[0])
		&& timer_a_toggle_pin_oe_n == !$past(dir_arr[0])))
		else $error("timer A pin drive wrong");
	pin_b_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && dir_arr[1] && oe_arr[1] && tog_arr[1]) |=> timer_b_toggle_pin_out)
		else $error("timer B toggle not on pin");

	// ----------------------------------------------------------------
	// Flag, stop, period write and interrupt checks
	// ----------------------------------------------------------------
	flag_b_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
		(dual_timer_control[`DIT_CTRL_B_OVF] && !wr_ctrl)
		|=> dual_timer_control[`DIT_CTRL_B_OVF])
		else $error("timer B flag cleared without write");
	flag_a_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_ctrl && !ovf_arr[0])
		|=> (dual_timer_control[`DIT_CTRL_A_OVF] == $past(pwdata[`DIT_CTRL_A_OVF])))
		else $error("timer A flag write lost");
	flag_b_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_ctrl && !ovf_arr[1])
		|=> (dual_timer_control[`DIT_CTRL_B_OVF] == $past(pwdata[`DIT_CTRL_B_OVF])))
		else $error("timer B flag write lost");
	stop_a_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && sel_arr[0] == `DIT_SEL_STOP)
		|=> !ovf_arr[0])
		else $error("stopped timer A overflowed");
	stop_b_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && sel_arr[1] == `DIT_SEL_STOP)
		|=> !ovf_arr[1])
		else $error("stopped timer B overflowed");
	per_a_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_a_per
		|=> (timer_a_period == $past(pwdata[7:0])))
		else $error("timer A period write lost");
	per_b_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		wr_b_per
		|=> (timer_b_period == $past(pwdata[7:0])))
		else $error("timer B period write lost");
	irq_a_raise_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && dual_timer_control[`DIT_CTRL_A_IE] && dual_timer_control[`DIT_CTRL_A_OVF])
		|=> irq)
		else $error("timer A request missing");
	irq_b_raise_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && dual_timer_control[`DIT_CTRL_B_IE] && dual_timer_control[`DIT_CTRL_B_OVF])
		|=> irq)
		else $error("timer B request missing");
	irq_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && !(dual_timer_control[`DIT_CTRL_A_IE] && dual_timer_control[`DIT_CTRL_A_OVF])
		&& !(dual_timer_control[`DIT_CTRL_B_IE] && dual_timer_control[`DIT_CTRL_B_OVF]))
		|=> !irq)
		else $error("request without enabled flag");

	// ----------------------------------------------------------------
	// Pin checks
	// ----------------------------------------------------------------
	pin_a_latch_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && dir_arr[0] && !oe_arr[0])
		|=> (timer_a_toggle_pin_out == $past(latch_arr[0])))
		else $error("timer A pin not latch value");
	pin_b_latch_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && dir_arr[1] && !oe_arr[1])
		|=> (timer_b_toggle_pin_out == $past(latch_arr[1])))
		else $error("timer B pin not latch value");
	pin_a_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && dir_arr[0] && oe_arr[0] && !latch_arr[0])
		|=> (timer_a_toggle_pin_out == $past(tog_arr[0])))
		else $error("timer A pin not following toggle");
	pin_b_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && dir_arr[1] && oe_arr[1] && !latch_arr[1])
		|=> (timer_b_toggle_pin_out == $past(tog_arr[1])))
		else $error("timer B pin not following toggle");
	pin_a_input_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && !dir_arr[0])
		|=> (!timer_a_toggle_pin_out && timer_a_toggle_pin_oe_n))
		else $error("timer A input pin driven");
	pin_b_input_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && !dir_arr[1])
		|=> (!timer_b_toggle_pin_out && timer_b_toggle_pin_oe_n))
		else $error("timer B input pin driven");
endmodule

//--- dit_top_bench.sv
// Self-checking bench for the dual interval timer, driven over APB
`timescale 1ns/1ps
`include "dit_params.svh"
module dit_top_bench;
	import dit_pkg::*;
	// ----------------------------------------------------------------
	// Byte addresses and stimulus
	// ----------------------------------------------------------------
	localparam logic [17:0] A_FUNC = {`DIT_IDX_PORT0_FUNC, 2'b00};
	localparam logic [17:0] A_CTRL = {`DIT_IDX_CTRL, 2'b00};
	localparam logic [17:0] A_APER = {`DIT_IDX_A_PERIOD, 2'b00};
	localparam logic [17:0] A_BPER = {`DIT_IDX_B_PERIOD, 2'b00};
	localparam logic [17:0] A_PIN = {`DIT_IDX_PIN_CTRL, 2'b00};
	localparam logic [17:0] A_ACNT = {`DIT_IDX_A_COUNT, 2'b00};
	localparam logic [17:0] A_BCNT = {`DIT_IDX_B_COUNT, 2'b00};
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = '0;
	dit_word_t pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	dit_word_t prdata;
	logic pready, pslverr, irq;
	logic a_in = 1'b0;
	logic b_in = 1'b0;
	logic a_out, a_oe_n, b_out, b_oe_n;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int last_wr = 0;
	dit_word_t rd;
	logic err;

	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	dit_top dit_top_i(.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .timer_a_toggle_pin_in(a_in),
		.timer_a_toggle_pin_out(a_out), .timer_a_toggle_pin_oe_n(a_oe_n),
		.timer_b_toggle_pin_in(b_in), .timer_b_toggle_pin_out(b_out),
		.timer_b_toggle_pin_oe_n(b_oe_n));

	// ----------------------------------------------------------------
	// Compare and report
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("Counts: %0d mismatches in %0d checks", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk8(input dit_word_t got, input dit_word_t exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t bit got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkn(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			bad_count++;
			$display("[ERR] t=%0t cycles got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ----------------------------------------------------------------
	// APB master and pin helpers
	// ----------------------------------------------------------------
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && n < 100) begin
			n++;
			@(posedge sys_clk);
		end
		if (n >= 100)
			chk1(1'b0, 1'b1);
		rd = prdata;
		err = pslverr;
		last_wr = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [17:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk8(rd, {24'h0, e});
	endtask

	function automatic logic pin(input int t);
		return t ? b_out : a_out;
	endfunction

	// Waits for the next change of a toggle pin, bounded
	task automatic next_edge(input int t, output int at);
		logic v;
		int n;
		v = pin(t);
		n = 0;
		while (pin(t) === v && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 2000)
			chk1(1'b0, 1'b1);
		at = cyc;
	endtask

	task automatic steady(input logic ea, input logic eb, input logic eo);
		repeat (30) begin
			@(posedge sys_clk);
			chk1(a_out, ea);
			chk1(b_out, eb);
			chk1(a_oe_n, eo);
			chk1(b_oe_n, eo);
		end
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		int e0, e1, s0, d0, p;
		logic [7:0] ie, ov, cv;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rdc(A_FUNC, 8'h00);
		rdc(A_CTRL, 8'h00);
		rdc(A_APER, 8'h00);
		rdc(A_BPER, 8'h00);
		chk1(irq, 1'b0);
		chk1(a_oe_n, 1'b1);
		apb(1'b0, 18'h00000, 8'h00);
		chk1(err, 1'b1);
		a_in <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rdc(A_PIN, 8'h10);
		wr(A_PIN, 8'h0c);
		wr(A_FUNC, 8'hc0);
		wr(A_APER, 8'h02);
		wr(A_BPER, 8'h05);
		// Every select of both timers: period, flag, interrupt, stop
		for (int t = 0; t < 2; t++) begin
			for (int s = 1; s < 4; s++) begin
				p = t ? 6 : 3;
				ie = t ? 8'h04 : 8'h01;
				ov = t ? 8'h08 : 8'h02;
				cv = 8'(s << (t ? 6 : 4)) | ie;
				wr(A_CTRL, cv);
				next_edge(t, e0);
				next_edge(t, e1);
				chkn(e1 - e0, p * (1 << (2 * s)));
				rdc(A_CTRL, cv | ov);
				chk1(irq, 1'b1);
				wr(A_CTRL, 8'h00);
				// Pin flop still shows the old toggle one edge after the stop
				repeat (3) @(posedge sys_clk);
				chk1(irq, 1'b0);
				chk1(pin(t), 1'b0);
				rdc(t ? A_BCNT : A_ACNT, 8'h00);
			end
		end
		// A period write while running restarts the count
		wr(A_APER, 8'h05);
		wr(A_BPER, 8'h05);
		for (int t = 0; t < 2; t++) begin
			wr(A_CTRL, t ? 8'h40 : 8'h10);
			s0 = last_wr;
			next_edge(t, e0);
			d0 = e0 - s0;
			repeat (5) @(posedge sys_clk);
			wr(t ? A_BPER : A_APER, 8'h05);
			s0 = last_wr;
			next_edge(t, e1);
			// Pin flop and edge sampling add two cycles to the 24-cycle period
			chkn(d0, 6 * 4 + 2);
			chkn(e1 - s0, d0);
			wr(A_CTRL, 8'h00);
		end
		// Pin multiplexing with both timers running
		wr(A_CTRL, 8'h50);
		wr(A_FUNC, 8'h00);
		wr(A_PIN, 8'h0c);
		steady(1'b0, 1'b0, 1'b0);
		wr(A_PIN, 8'h0f);
		repeat (2) @(posedge sys_clk);
		steady(1'b1, 1'b1, 1'b0);
		wr(A_FUNC, 8'hc0);
		repeat (2) @(posedge sys_clk);
		steady(1'b1, 1'b1, 1'b0);
		wr(A_PIN, 8'h00);
		repeat (2) @(posedge sys_clk);
		steady(1'b0, 1'b0, 1'b1);
		report_and_stop();
	end

	initial begin
		#2_500_000;
		bad_count++;
		report_and_stop();
	end
endmodule
